/* File: rtc_tx_ctrl.sv */
// Channel decode, synthesizer load sequencing, ready output and data path.
// Assumes pin inputs are asynchronous and a classic Wishbone master.
// Notes on behaviour
// - From reset, ready rises within the turn-on time.
// - A new valid channel is locked and ready within the channel change time.
// - Channel select pins read 0 at ground, 1 at supply.
// - Parallel code 0..7 maps to 903.37 through 921.37 MHz.
// - The block loads the synthesizer itself; no external sequence.
// - Data passes through unchanged, without framing or rate limits.
// - Any data rate from 100 bps to 56 kbps is accepted.
// - Power-down low halts all function; high means active. The Wishbone port still answers and takes writes in power-down.
// - Ready rises only after lock on the selected channel; a change during the lock wait still gives one ready cycle on the old channel.
// - Start-up sequence runs at reset and on power-down release.
// - Mode select high means serial channel selection is used.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module rtc_tx_ctrl #(
  parameter int TURN_ON_CYCLES = rtc_pkg::TURN_ON_CYCLES,
  parameter int CHANNEL_CHANGE_CYCLES = rtc_pkg::CHANNEL_CHANGE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control pins
  input wire logic power_down_n,
  input wire logic mode_sel,
  input wire logic chan_sel_0,
  input wire logic chan_sel_1,
  input wire logic chan_sel_2,
  input wire logic data_in,
  // Outputs toward radio and host, and the host's data ready input
  output logic ready_to_send,
  output logic data_out,
  output logic data_valid,
  input wire logic data_ready,
  output logic [15:0] synth_freq_khz_off,
  output logic synth_load,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // Two-flop synchronisers for every pin input.
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  wire logic [5:0] pin_raw = {data_in, chan_sel_2, chan_sel_1, chan_sel_0, mode_sel, power_down_n};
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= 6'h01;
      pin_s2_q <= 6'h01;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end
  wire logic pdn_n_s = pin_s2_q[0];
  wire logic serial_mode = pin_s2_q[1];
  wire logic [2:0] par_code = pin_s2_q[4:2];
  wire logic data_s = pin_s2_q[5];

  // Registers.
  logic [6:0] ser_ch_q;
  logic relock_req_q;
  logic [31:0] lock_cycles_q;
  logic [31:0] cnt_q;
  logic [31:0] budget_q;
  logic [6:0] cur_ch_q;
  logic late_q;
  rtc_pkg::rtc_state_t state_q;
  rtc_pkg::rtc_state_t state_d;

  // Channel selection: the parallel channels are not evenly spaced, so they come from a table.
  wire logic [15:0] par_off = rtc_pkg::PAR_OFF_KHZ[par_code];
  wire logic [15:0] ser_off = 16'(ser_ch_q) * rtc_pkg::SER_STEP_KHZ;
  wire logic [6:0] sel_ch = serial_mode ? ser_ch_q : {4'h0, par_code};
  wire logic [15:0] want_off = serial_mode ? (16'(rtc_pkg::SER_BASE_KHZ - rtc_pkg::FREQ_BASE_KHZ) + ser_off)
                                           : par_off;
  wire logic ch_changed = (sel_ch != cur_ch_q) || relock_req_q;
  wire logic locked = (cnt_q >= lock_cycles_q);
  localparam logic [31:0] LOCK_CAP = 32'(CHANNEL_CHANGE_CYCLES - rtc_pkg::LOCK_MARGIN_CYCLES);

  // Wishbone decode.
  wire logic wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire logic hit_ctrl = wb_adr_i == rtc_pkg::ADDR_CTRL;
  wire logic hit_stat = wb_adr_i == rtc_pkg::ADDR_STATUS;
  wire logic hit_freq = wb_adr_i == rtc_pkg::ADDR_FREQ;
  wire logic hit_lock = wb_adr_i == rtc_pkg::ADDR_LOCK;
  wire logic [31:0] rd_mux = hit_ctrl ? {23'h0, relock_req_q, 1'h0, ser_ch_q} :
                             hit_stat ? {24'h0, late_q, serial_mode, state_q, 1'h0, ready_to_send, pdn_n_s, 1'h0} :
                             hit_freq ? {16'h0, synth_freq_khz_off} :
                             hit_lock ? lock_cycles_q : 32'h00000000;

  // Start-up and relock sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      rtc_pkg::RTC_OFF: if (pdn_n_s) state_d = rtc_pkg::RTC_LOAD;
      rtc_pkg::RTC_LOAD: state_d = rtc_pkg::RTC_LOCK;
      rtc_pkg::RTC_LOCK: if (locked) state_d = rtc_pkg::RTC_READY;
      rtc_pkg::RTC_READY: if (ch_changed) state_d = rtc_pkg::RTC_LOAD;
      default: state_d = rtc_pkg::RTC_OFF;
    endcase
    if (!pdn_n_s) state_d = rtc_pkg::RTC_OFF;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= rtc_pkg::RTC_OFF;
      cnt_q <= 32'h00000000;
      budget_q <= 32'h00000000;
      cur_ch_q <= 7'h00;
      synth_freq_khz_off <= 16'h0000;
      synth_load <= 1'b0;
      ready_to_send <= 1'b0;
      late_q <= 1'b0;
    end else begin
      state_q <= state_d;
      synth_load <= state_d == rtc_pkg::RTC_LOAD;
      ready_to_send <= state_d == rtc_pkg::RTC_READY;
      if (state_d == rtc_pkg::RTC_LOAD) begin
        synth_freq_khz_off <= want_off;
        cur_ch_q <= sel_ch;
        cnt_q <= 32'h00000000;
        // The first load after power-up gets the longer budget.
        budget_q <= (state_q == rtc_pkg::RTC_OFF) ? 32'(TURN_ON_CYCLES) : 32'(CHANNEL_CHANGE_CYCLES);
      end else if (state_q == rtc_pkg::RTC_LOCK) begin
        cnt_q <= cnt_q + 32'h00000001;
        if (cnt_q >= budget_q) late_q <= 1'b1;
      end
    end
  end

  // Register writes; a relock request clears itself once the load starts.
  always_ff @(posedge clock) begin
    if (rst) begin
      ser_ch_q <= rtc_pkg::SER_DEFAULT_CH;
      relock_req_q <= 1'b0;
      lock_cycles_q <= rtc_pkg::LOCK_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
      if (wb_wr && hit_ctrl) begin
        ser_ch_q <= (wb_dat_i[6:0] > rtc_pkg::SER_MAX_CH) ? 7'h00 : wb_dat_i[6:0];
        relock_req_q <= wb_dat_i[rtc_pkg::CTRL_FORCE_RELOCK];
      end else if (state_d == rtc_pkg::RTC_LOAD) begin
        relock_req_q <= 1'b0;
      end
      // Lock time saturates a margin below the change budget, so synchroniser and load still fit.
      if (wb_wr && hit_lock) begin
        lock_cycles_q <= (wb_dat_i > LOCK_CAP) ? LOCK_CAP : wb_dat_i;
      end
    end
  end

  // Two-entry skid buffer: the head register drives the outputs and holds while the receiver
  // stalls, and the second entry catches the sample taken in the stall cycle. The pin cannot
  // be held off, so samples that arrive while both entries are full are dropped.
  logic skid_q;
  logic skid_vld_q;
  wire logic push = pdn_n_s;
  wire logic head_free = !data_valid || data_ready;
  wire logic skid_take = push && !head_free && !skid_vld_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      skid_q <= 1'b0;
      skid_vld_q <= 1'b0;
      data_valid <= 1'b0;
      data_out <= 1'b0;
    end else begin
      if (head_free) begin
        data_valid <= skid_vld_q || push;
        data_out <= skid_vld_q ? skid_q : data_s;
        skid_q <= data_s;
        skid_vld_q <= skid_vld_q && push;
      end else if (skid_take) begin
        skid_q <= data_s;
        skid_vld_q <= 1'b1;
      end
    end
  end
endmodule

/* File: rtc_pkg.sv */
// Constants shared by the transmitter channel and ready control block.
// Assumes a 200 MHz system clock and a classic Wishbone register bus.
package rtc_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TURN_ON_TIME_US = 10000;
  localparam int CHANNEL_CHANGE_TIME_US = 1500;
  localparam int TURN_ON_CYCLES = TURN_ON_TIME_US * CLK_MHZ;
  localparam int CHANNEL_CHANGE_CYCLES = CHANNEL_CHANGE_TIME_US * CLK_MHZ;
  localparam int LOCK_CYCLES_DEFAULT = 200;
  // Low 16 bits of the carrier in kHz; only their difference is used, so the wrap is harmless.
  localparam logic [15:0] FREQ_BASE_KHZ = 16'hC8CA;
  localparam logic [15:0] SER_BASE_KHZ = 16'hC5DC;
  localparam logic [6:0] SER_DEFAULT_CH = 7'h32;
  localparam logic [6:0] SER_MAX_CH = 7'h64;
  localparam logic [15:0] SER_STEP_KHZ = 16'h00FA;
  // Parallel channel offsets in kHz above the lowest carrier, indexed by the channel code.
  localparam logic [7:0][15:0] PAR_OFF_KHZ = {16'h4650, 16'h4074, 16'h2EE0, 16'h2328,
                                              16'h1770, 16'h1194, 16'h0BB8, 16'h0000};
  // Cycles kept free for the pin synchroniser and the load cycle inside the change budget.
  localparam int LOCK_MARGIN_CYCLES = 8;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_FREQ = 4'h8;
  localparam logic [3:0] ADDR_LOCK = 4'hC;
  localparam int CTRL_SER_CH_LSB = 0;
  localparam int CTRL_FORCE_RELOCK = 8;
  localparam logic [31:0] LOCK_RESET = 32'h000000C8;
  typedef enum logic [1:0] {RTC_OFF, RTC_LOAD, RTC_LOCK, RTC_READY} rtc_state_t;
endpackage

/* File: rtc_tx_ctrl_assertions.sv */
// Timing checks on the pins of the channel and ready control block.
// Assumes binding to rtc_tx_ctrl with shortened turn-on and change counts.
`timescale 1ns/1ps
module rtc_tx_ctrl_assertions #(
  parameter int TURN_ON_CYCLES = 500,
  parameter int CHANNEL_CHANGE_CYCLES = 300
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control pins
  input wire logic power_down_n,
  input wire logic mode_sel,
  input wire logic chan_sel_0,
  input wire logic chan_sel_1,
  input wire logic chan_sel_2,
  // Outputs, data stream and bus
  input wire logic ready_to_send,
  input wire logic synth_load,
  input wire logic [15:0] synth_freq_khz_off,
  input wire logic data_out,
  input wire logic data_valid,
  input wire logic data_ready,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wake;
    !power_down_n ##1 power_down_n;
  endsequence
  sequence s_hop;
    ready_to_send && !mode_sel && power_down_n && $changed({chan_sel_2, chan_sel_1, chan_sel_0});
  endsequence
  // Four low samples cover the two-stage pin synchroniser plus the output register.
  AST_PDN_OFF: assert property (!power_down_n [*4] |-> !ready_to_send) else $error("ready in power down");
  AST_TURN_ON: assert property ($fell(rst) && power_down_n |-> ##[1:TURN_ON_CYCLES] ready_to_send)
    else $error("late ready after reset");
  AST_WAKE: assert property (s_wake |-> ##[1:TURN_ON_CYCLES] ready_to_send) else $error("late ready on wake");
  AST_HOP: assert property (s_hop |-> ##[1:10] !ready_to_send ##[1:CHANNEL_CHANGE_CYCLES] ready_to_send)
    else $error("channel change not relocked in time");
  AST_LOAD_LOW: assert property (synth_load |-> !ready_to_send ##1 !ready_to_send) else $error("ready during load");
  AST_LOAD_PULSE: assert property (synth_load |=> !synth_load) else $error("load strobe too long");
  AST_FREQ_HOLD: assert property (ready_to_send && $past(ready_to_send) |-> $stable(synth_freq_khz_off))
    else $error("frequency moved while ready");
  AST_STALL_HOLD: assert property (data_valid && !data_ready |=> data_valid && $stable(data_out))
    else $error("data moved during stall");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
endmodule
bind rtc_tx_ctrl rtc_tx_ctrl_assertions #(.TURN_ON_CYCLES(TURN_ON_CYCLES),
  .CHANNEL_CHANGE_CYCLES(CHANNEL_CHANGE_CYCLES)) u_chk (.clock, .rst, .power_down_n, .mode_sel, .chan_sel_0,
  .chan_sel_1, .chan_sel_2, .ready_to_send, .synth_load, .synth_freq_khz_off, .data_out, .data_valid,
  .data_ready, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* File: rtc_rx_model.sv */
// Receiver on the far side of the data buffer.
// Assumes the block offers one data bit per valid cycle.
`timescale 1ns/1ps
module rtc_rx_model (
  // Clock and stall control
  input wire logic clock,
  input wire logic stall,
  // Data stream
  input wire logic data_valid,
  input wire logic data_out,
  output logic data_ready,
  output logic last_bit
);
  // A stall holds ready low so the buffer must keep its words.
  assign data_ready = !stall;
  always_ff @(posedge clock) begin
    if (data_valid && data_ready) begin
      last_bit <= data_out;
    end
  end
endmodule

/* File: rtc_tx_ctrl_tb.sv */
// Self-checking bench for the channel and ready control block.
// Assumes shortened counts of 500 and 300 cycles.
`timescale 1ns/1ps
module rtc_tx_ctrl_tb;
  logic clock = '0, rst = '1, power_down_n = '1, mode_sel = '0, data_in = '0, stall = '0;
  logic [2:0] cs = '0;
  logic wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic ready_to_send, data_out, data_valid, data_ready, synth_load, wb_ack_o, last_bit;
  logic [15:0] synth_freq_khz_off;
  logic [15:0] ft [8] = '{16'h0000, 16'h0BB8, 16'h1194, 16'h1770, 16'h2328, 16'h2EE0, 16'h4074, 16'h4650};
  int bad_count = 0, compares = 0, cyc_n = 0;
  rtc_tx_ctrl #(.TURN_ON_CYCLES(500), .CHANNEL_CHANGE_CYCLES(300)) dut (.clock, .rst, .power_down_n, .mode_sel,
    .chan_sel_0(cs[0]), .chan_sel_1(cs[1]), .chan_sel_2(cs[2]), .data_in, .ready_to_send, .data_out, .data_valid,
    .data_ready, .synth_freq_khz_off, .synth_load, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  rtc_rx_model rx (.clock, .stall, .data_valid, .data_out, .data_ready, .last_bit);
  always #2.5 clock = ~clock;
  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A hang counts as a mismatch; the full run needs about 3100 cycles.
  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hF, d};
    do @(posedge clock); while (wb_ack_o !== 1'h1);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task wait_rdy(input logic lvl, input int lim);
    for (int n = 0; n < lim && ready_to_send !== lvl; n++) @(posedge clock);
    chk("ready_to_send", lvl, ready_to_send);
  endtask
  task t_par;
    for (int i = 1; i < 9; i++) begin
      @(posedge clock);
      cs <= 3'(i);
      wait_rdy(0, 10);
      wait_rdy(1, 300);
      chk("freq", ft[i % 8], synth_freq_khz_off);
    end
  endtask
  task t_pdn;
    @(posedge clock);
    power_down_n <= '0;
    repeat (10) @(posedge clock);
    chk("ready_off", 0, ready_to_send);
    chk("valid_off", 0, data_valid);
    power_down_n <= '1;
    wait_rdy(1, 500);
  endtask
  task t_ser;
    logic [31:0] r;
    @(posedge clock);
    mode_sel <= '1;
    wait_rdy(0, 10);
    wait_rdy(1, 300);
    chk("freq", 16'h2DE6, synth_freq_khz_off);
    wb(1, rtc_pkg::ADDR_CTRL, 32'h00000064, r);
    wait_rdy(0, 10);
    wait_rdy(1, 300);
    chk("freq", 16'h5EBA, synth_freq_khz_off);
    wb(0, rtc_pkg::ADDR_LOCK, 32'h0, r);
    chk("lock", 32'h000000C8, r);
    wb(1, rtc_pkg::ADDR_LOCK, 32'hFFFFFFFF, r);
    wb(0, rtc_pkg::ADDR_LOCK, 32'h0, r);
    chk("lock_cap", 32'(300 - rtc_pkg::LOCK_MARGIN_CYCLES), r);
    wb(1, rtc_pkg::ADDR_CTRL, 32'h00000164, r);
    wait_rdy(0, 10);
    wait_rdy(1, 300);
    wb(0, rtc_pkg::ADDR_CTRL, 32'h0, r);
    chk("ctrl", 32'h00000064, r);
    wb(0, rtc_pkg::ADDR_STATUS, 32'h0, r);
    chk("status", 32'h00000076, r);
    wb(0, rtc_pkg::ADDR_FREQ, 32'h0, r);
    chk("freq_reg", 32'h00005EBA, r);
    wb(1, rtc_pkg::ADDR_LOCK, 32'h000000C8, r);
    wb(0, 4'h2, 32'h0, r);
    chk("unmapped", 32'h0, r);
    @(posedge clock);
    mode_sel <= '0;
    wait_rdy(0, 10);
    wait_rdy(1, 300);
  endtask
  task t_dat;
    wait_rdy(1, 10);
    @(posedge clock);
    {stall, data_in} <= 2'h3;
    repeat (20) @(posedge clock);
    chk("held", 0, data_out);
    chk("valid", 1, data_valid);
    stall <= '0;
    repeat (10) @(posedge clock);
    chk("data", 1, last_bit);
    data_in <= '0;
    repeat (10) @(posedge clock);
    chk("data", 0, last_bit);
    power_down_n <= '0;
    wait_rdy(0, 10);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= '0;
    wait_rdy(1, 500);
    chk("freq", ft[0], synth_freq_khz_off);
    t_par();
    t_pdn();
    t_ser();
    t_dat();
    results();
  end
endmodule
